// [dv/spcr_regs_tb.sv]
// Self-checking testbench for the switch port control register bank
`timescale 1ns/1ps
`include "spcr_cfg.svh"
module spcr_regs_tb;
   localparam int unsigned TCYC = 16;
   localparam int unsigned ECYC = 20;
   localparam logic [11:0] OFFS [8] = '{`SPCR_OFF_IRQ_ROUTE, `SPCR_OFF_PORT_ROLE, `SPCR_OFF_RATE_DEEMPH,
      `SPCR_OFF_COMPLIANCE, `SPCR_OFF_EVEN_PHY, `SPCR_OFF_ODD_PHY, `SPCR_OFF_EVEN_HOLD, `SPCR_OFF_ODD_HOLD};
   localparam logic [31:0] MASKS [8] = '{`SPCR_IRQ_RW_MASK, `SPCR_ROLE_RW_MASK, 32'hFFFFFFFF,
      `SPCR_COMPL_RW_MASK, `SPCR_PHY_RW_MASK, `SPCR_PHY_RW_MASK, `SPCR_HOLD_RW_MASK, `SPCR_HOLD_RW_MASK};
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic sw_wr = 1'b0, sw_rd = 1'b0, ld_wr = 1'b0;
   logic [11:0] sw_addr = 12'h000, ld_addr = 12'h000;
   logic [31:0] sw_wdata = 32'h0, ld_wdata = 32'h0, lfsr = 32'h00011783;
   logic gpio_irq_req = 1'b0, doorbell_irq_req = 1'b0, expander_write_done = 1'b0;
   logic [3:0] strap_upstream_port = 4'h0, strap_bridged_port = 4'h0;
   logic [15:0] slot_power_good_inputs = 16'h0000, lane_up = 16'h0000;
   logic [31:0] sw_rdata;
   logic [3:0] upstream_port_number, bridged_domain_port_number;
   logic [1:0] slot_timer_period;
   logic [5:0] slot_output_pins;
   logic [15:0] slot_power_good, link_rate_sel, deemphasis_sel, port_loopback, port_scramble_off;
   logic [15:0] port_compliance_rx, port_training_hold, port_quiet_hold;
   logic sw_rvalid, legacy_interrupt_pin_n, gpio_intx_msg, doorbell_intx_msg, turn_off_message_enable;
   logic slot_timer_tick, bridged_port_serial_slot_enable, downstream_serial_slot_enable, wide_expander_select;
   logic expander_pin_direction, expander_pin_value, expander_write_start, compliance_enter;
   logic [31:0] rv [8];
   int error_cnt = 0, compares = 0, cyc = 0, n;

   spcr_regs #(.TIMER_128_CYC(TCYC), .EXP_WRITE_CYC(ECYC)) u_spcr_regs (.*);

   always #50 ref_clk = ~ref_clk;

   // Cycle ceiling against a hang
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         error_cnt = error_cnt + 1;
         end_sim();
      end
   end

   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h0);
      return lfsr;
   endfunction

   // Expected per-port vector from the even and odd registers
   function automatic logic [15:0] spread(input logic [31:0] e, input logic [31:0] o, input int b, input int s);
      for (int i = 0; i < 16; i++)
         spread[i] = i[0] ? o[b + s * (i / 2)] : e[b + s * (i / 2)];
   endfunction

   task automatic step(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares = compares + 1;
      if (g !== e)
      begin
         error_cnt = error_cnt + 1;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic ld, input logic [11:0] a, input logic [31:0] d);
      step(1);
      if (ld)
         {ld_wr, ld_addr, ld_wdata} = {1'b1, a, d};
      else
         {sw_wr, sw_addr, sw_wdata} = {1'b1, a, d};
      step(1);
      sw_wr = 1'b0;
      ld_wr = 1'b0;
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      step(1);
      sw_rd = 1'b1;
      sw_addr = a;
      step(1);
      sw_rd = 1'b0;
      chk("rvalid", 32'h1, {31'h0, sw_rvalid});
      chk($sformatf("rdata_%h", a), e, sw_rdata);
   endtask

   task automatic tdone(input string nm);
      $display("Test %s done", nm);
   endtask

   task automatic end_sim();
      $display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      step(8);
      arst_n = 1'b1;
      step(3);
      foreach (OFFS[i])
         rdc(OFFS[i], 32'h0);
      rdc(`SPCR_OFF_HOT_PLUG, `SPCR_HP_RESET);
      rdc(`SPCR_OFF_L1_HDR, 32'h9001001E);
      chk("rst_pins", 32'hD, {28'h0, legacy_interrupt_pin_n, downstream_serial_slot_enable, slot_timer_period});
      wr(1'b0, `SPCR_OFF_LANE_STAT, 32'hFFFFFFFF);
      wr(1'b0, `SPCR_OFF_L1_HDR, 32'hFFFFFFFF);
      rdc(`SPCR_OFF_L1_HDR, 32'h9001001E);
      rdc(12'h100, 32'h0);
      wr(1'b1, `SPCR_OFF_L1_HDR, 32'hABC00000);
      rdc(`SPCR_OFF_L1_HDR, 32'hABC1001E);
      tdone("reset_and_refusals");
      // Random rounds, odd rounds through the loader port
      for (int r = 0; r < 6; r++)
      begin
         {lane_up, slot_power_good_inputs} = rnd();
         {strap_upstream_port, strap_bridged_port} = lfsr[7:0];
         for (int i = 0; i < 8; i++)
         begin
            rv[i] = r == 0 ? 32'hFFFFFFFF : rnd();
            if (i == 3 && r inside {1, 2})
               rv[i] = 32'(r);
            wr(r[0], OFFS[i], rv[i]);
         end
         step(3);
         foreach (OFFS[i])
            rdc(OFFS[i], rv[i] & MASKS[i]);
         rdc(`SPCR_OFF_LANE_STAT, {12'h0, lane_up[7:4], lane_up[15:8], 4'h0, lane_up[3:0]});
         chk("rate", rv[2], {deemphasis_sel, link_rate_sel});
         chk("compl", {31'h0, rv[3][15:0] == 16'h1}, {31'h0, compliance_enter});
         chk("loop", {16'h0, spread(rv[4], rv[5], 0, 4)}, {16'h0, port_loopback});
         chk("scr", {16'h0, spread(rv[4], rv[5], 1, 4)}, {16'h0, port_scramble_off});
         chk("crx", {16'h0, spread(rv[4], rv[5], 2, 4)}, {16'h0, port_compliance_rx});
         chk("dis", {16'h0, spread(rv[6], rv[7], 0, 1)}, {16'h0, port_training_hold});
         chk("quiet", {16'h0, spread(rv[6], rv[7], 8, 1)}, {16'h0, port_quiet_hold});
         chk("role", {24'h0, rv[1][15] ? {rv[1][11:8], rv[1][27:24]} : {strap_upstream_port, strap_bridged_port}},
            {24'h0, upstream_port_number, bridged_domain_port_number});
      end
      tdone("register_rounds");
      for (int k = 0; k < 16; k++)
      begin
         if (k[1:0] == 2'h0)
            wr(1'b0, `SPCR_OFF_IRQ_ROUTE, {24'h0, k[3:2], 6'h0});
         {gpio_irq_req, doorbell_irq_req} = k[1:0];
         step(3);
         chk("irq", {29'h0, !(k[1] & k[2] | k[0] & k[3]), k[1] & !k[2], k[0] & !k[3]},
            {29'h0, legacy_interrupt_pin_n, gpio_intx_msg, doorbell_intx_msg});
      end
      tdone("interrupt_routing");
      for (int k = 0; k < 4; k++)
      begin
         rv[1] = k == 0 ? 32'hFFEFFFFF : rnd() & 32'hFFEFFFFF;
         rv[0] = rv[1] & 32'h07EF105C;
         slot_power_good_inputs = lfsr[31:16];
         wr(k[0], `SPCR_OFF_HOT_PLUG, rv[1]);
         step(2);
         rdc(`SPCR_OFF_HOT_PLUG, rv[0]);
         chk("hp", {23'h0, rv[0][2], rv[0][4:3], rv[0][12], !rv[0][16], rv[0][17], rv[0][18], rv[0][19], 1'b0},
            {23'h0, turn_off_message_enable, slot_timer_period, bridged_port_serial_slot_enable,
            downstream_serial_slot_enable, wide_expander_select, expander_pin_direction, expander_pin_value,
            1'b0});
         chk("pg", {16'h0, slot_power_good_inputs ^ {16{rv[0][6]}}}, {16'h0, slot_power_good});
      end
      tdone("hot_plug_fields");
      for (int c = 0; c < 4; c++)
      begin
         wr(1'b0, `SPCR_OFF_HOT_PLUG, {27'h0, 2'(c), 3'h0});
         for (int t = 0; t < 3; t++)
         begin
            n = 0;
            step(1);
            while (slot_timer_tick !== 1'b1 && n < 300)
            begin
               step(1);
               n++;
            end
         end
         chk("period", TCYC << (c == 0 ? 0 : c - 1), n + 1);
      end
      tdone("slot_timer");
      for (int k = 0; k < 2; k++)
      begin
         rv[0] = {5'h0, 6'(rnd()), 1'b1, 20'h0};
         wr(1'b0, `SPCR_OFF_HOT_PLUG, rv[0]);
         chk("reload", {25'h0, 1'b1, rv[0][26:21]}, {25'h0, expander_write_start, slot_output_pins});
         rdc(`SPCR_OFF_HOT_PLUG, (rv[0] & 32'h07E00000) | 32'h8000);
         expander_write_done = !k[0];
         step(1);
         expander_write_done = 1'b0;
         step(k * (ECYC + 4));
         rdc(`SPCR_OFF_HOT_PLUG, rv[0] & 32'h07E00000);
      end
      tdone("output_reload");
      end_sim();
   end
endmodule

// [include/spcr_cfg.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef SPCR_CFG_SVH
`define SPCR_CFG_SVH
`define SPCR_OFF_IRQ_ROUTE 12'h1C8
`define SPCR_OFF_PORT_ROLE 12'h1DC
`define SPCR_OFF_HOT_PLUG 12'h1E0
`define SPCR_OFF_LANE_STAT 12'h1F4
`define SPCR_OFF_RATE_DEEMPH 12'h208
`define SPCR_OFF_COMPLIANCE 12'h20C
`define SPCR_OFF_EVEN_PHY 12'h220
`define SPCR_OFF_ODD_PHY 12'h224
`define SPCR_OFF_EVEN_HOLD 12'h230
`define SPCR_OFF_ODD_HOLD 12'h234
`define SPCR_OFF_L1_HDR 12'h270
`define SPCR_IRQ_GPIO_PIN_BIT 6
`define SPCR_IRQ_DBELL_PIN_BIT 7
`define SPCR_IRQ_RW_MASK 32'h000000FF
`define SPCR_ROLE_SW_BIT 15
`define SPCR_ROLE_UP_LSB 8
`define SPCR_ROLE_BR_LSB 24
`define SPCR_ROLE_RW_MASK 32'h0F008F00
`define SPCR_HP_TURNOFF_BIT 2
`define SPCR_HP_TIMER_LSB 3
`define SPCR_HP_PG_POL_BIT 6
`define SPCR_HP_BR_SLOT_BIT 12
`define SPCR_HP_PENDING_BIT 15
`define SPCR_HP_DN_DIS_BIT 16
`define SPCR_HP_WIDE_BIT 17
`define SPCR_HP_DIR_BIT 18
`define SPCR_HP_VAL_BIT 19
`define SPCR_HP_RELOAD_BIT 20
`define SPCR_HP_RVAL_LSB 21
`define SPCR_HP_RW_MASK 32'h07EF105C
`define SPCR_HP_RESET 32'h00000008
`define SPCR_LANE_MASK 32'h000FFF0F
`define SPCR_PHY_RW_MASK 32'h77777777
`define SPCR_HOLD_RW_MASK 32'h00FFFFFF
`define SPCR_COMPL_RW_MASK 32'h0000FFFF
`define SPCR_L1_CAP_ID 16'h001E
`define SPCR_L1_VERSION 4'h1
`define SPCR_L1_NEXT_RESET 12'h900
`define SPCR_TIMER_128_MS 128
`define SPCR_CLK_KHZ 10000
`define SPCR_TIMER_128_CYC ((`SPCR_TIMER_128_MS) * (`SPCR_CLK_KHZ))
`define SPCR_EXP_WRITE_CYC 64
`endif

// [include/spcr_pkg.sv]
// Types for the switch port control register bank
package spcr_pkg;
   typedef enum logic [1:0]
   {
      SPCR_TMR_RSVD,
      SPCR_TMR_128,
      SPCR_TMR_256,
      SPCR_TMR_512
   } spcr_timer_t;
   typedef enum {SPCR_EXP_IDLE, SPCR_EXP_BUSY} spcr_exp_state_t;
endpackage

// [logic/spcr_regs.sv]
// Global and per-port control register bank of the packet switch
//
// Notes on behaviour
// [RULE1] Bit 6 of routing: 0 sends in-band message for GPIO interrupts, 1 drives pin.
// [RULE2] Bit 7 of routing: same choice for bridged doorbell interrupts.
// [RULE3] With bit 15 set, upstream port from 11:8, bridged port from 27:24.
// [RULE4] Hot plug bit 2 allows the turn-off message on downstream ports.
// [RULE5] Two-bit timer: 01 128 ms, 10 256 ms, 11 512 ms; 00 reserved; reset 01.
// [RULE6] Bit 6 sets power-good input polarity: 0 active high, 1 active low.
// [RULE7] Bit 12 enables serial hot plug on the bridged port.
// [RULE8] Read-only bit 15 reads one while an expander output write is pending.
// [RULE9] Bit 16 disables serial hot plug for all downstream ports.
// [RULE10] Bit 17 selects wide expander, clear selects 16-pin expander.
// [RULE11] Bit 18 is expander pin direction, bit 19 expander pin value.
// [RULE12] Writing one to bit 20 reloads outputs from 26:21, then bit clears.
// [RULE13] Lane status: 3:0 lanes 3-0, 15:8 lanes 15-8, 19:16 lanes 7-4.
// [RULE14] Rate field 15:0 and de-emphasis field 31:16 are plain test controls.
// [RULE15] Compliance field value 1 puts the link into compliance mode; resets zero.
// [RULE16] Per-port loopback, scrambler disable, compliance receive in 220h and 224h.
// [RULE17] Disable bits 7:0 force a port's training machine into quiet detect.
// [RULE18] Quiet bits 15:8 keep a port's training machine in quiet detect.
// [RULE19] Bits 0-7 map to even ports at 230h and odd ports at 234h.
// [RULE20] L1 header reads id 001Eh, version 1h, next pointer default 900h.
// [RULE21] Reserved bits read zero; loader writes reach the same loadable fields.
`timescale 1ns/1ps
`include "spcr_cfg.svh"
module spcr_regs #(
   parameter int unsigned TIMER_128_CYC = `SPCR_TIMER_128_CYC,
   parameter int unsigned EXP_WRITE_CYC = `SPCR_EXP_WRITE_CYC
)(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic sw_wr,
   input wire logic sw_rd,
   input wire logic [11:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   output logic [31:0] sw_rdata,
   output logic sw_rvalid,
   input wire logic ld_wr,
   input wire logic [11:0] ld_addr,
   input wire logic [31:0] ld_wdata,
   input wire logic gpio_irq_req,
   input wire logic doorbell_irq_req,
   output logic legacy_interrupt_pin_n,
   output logic gpio_intx_msg,
   output logic doorbell_intx_msg,
   input wire logic [3:0] strap_upstream_port,
   input wire logic [3:0] strap_bridged_port,
   output logic [3:0] upstream_port_number,
   output logic [3:0] bridged_domain_port_number,
   output logic turn_off_message_enable,
   output logic [1:0] slot_timer_period,
   output logic slot_timer_tick,
   input wire logic [15:0] slot_power_good_inputs,
   output logic [15:0] slot_power_good,
   output logic bridged_port_serial_slot_enable,
   output logic downstream_serial_slot_enable,
   output logic wide_expander_select,
   output logic expander_pin_direction,
   output logic expander_pin_value,
   output logic [5:0] slot_output_pins,
   output logic expander_write_start,
   input wire logic expander_write_done,
   input wire logic [15:0] lane_up,
   output logic [15:0] link_rate_sel,
   output logic [15:0] deemphasis_sel,
   output logic compliance_enter,
   output logic [15:0] port_loopback,
   output logic [15:0] port_scramble_off,
   output logic [15:0] port_compliance_rx,
   output logic [15:0] port_training_hold,
   output logic [15:0] port_quiet_hold
);
   logic rst_meta_reg;
   logic rst_sync_n;
   logic [31:0] irq_reg;
   logic [31:0] role_reg;
   logic [31:0] hp_reg;
   logic [31:0] lane_reg;
   logic [31:0] rate_reg;
   logic [31:0] compl_reg;
   logic [31:0] even_phy_reg;
   logic [31:0] odd_phy_reg;
   logic [31:0] even_hold_reg;
   logic [31:0] odd_hold_reg;
   logic [11:0] l1_next_reg;
   logic pending_reg;
   logic [31:0] exp_cnt_reg;
   logic [31:0] tmr_cnt_reg;
   logic [31:0] tmr_limit;
   logic wr_en;
   logic [11:0] wr_addr;
   logic [31:0] wr_data;
   logic reload_hit;
   spcr_pkg::spcr_exp_state_t exp_state_reg;
   spcr_pkg::spcr_timer_t tmr_sel;

   // Merge a write under a writable-bit mask
   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [31:0] mask);
      merge = (old_v & ~mask) | (new_v & mask);
   endfunction

   // Spread one bit of every port group into a port-ordered vector
   function automatic logic [15:0] spread(input logic [31:0] ev, input logic [31:0] od, input int pos,
                                          input int stride);
      logic [15:0] v;
      v = 16'h0000;
      for (int p = 0; p < 8; p++)
      begin
         v[2 * p] = ev[stride * p + pos];
         v[2 * p + 1] = od[stride * p + pos];
      end
      spread = v;
   endfunction

   // Reset release through two flops
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_n <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_n <= rst_meta_reg;
      end
   end

   // Software wins over the loader when both write
   always_comb
   begin
      wr_en = sw_wr | ld_wr;
      wr_addr = sw_wr ? sw_addr : ld_addr; // [RULE21]
      wr_data = sw_wr ? sw_wdata : ld_wdata;
      reload_hit = wr_en && (wr_addr == `SPCR_OFF_HOT_PLUG) && wr_data[`SPCR_HP_RELOAD_BIT];
   end

   // Writable registers, reserved bits held at zero
   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         irq_reg <= 32'h00000000;
         role_reg <= 32'h00000000;
         hp_reg <= `SPCR_HP_RESET; // [RULE5]
         rate_reg <= 32'h00000000;
         compl_reg <= 32'h00000000; // [RULE15]
         even_phy_reg <= 32'h00000000;
         odd_phy_reg <= 32'h00000000;
         even_hold_reg <= 32'h00000000;
         odd_hold_reg <= 32'h00000000;
         l1_next_reg <= `SPCR_L1_NEXT_RESET; // [RULE20]
      end
      else if (wr_en)
      begin
         unique case (wr_addr)
            `SPCR_OFF_IRQ_ROUTE: irq_reg <= merge(irq_reg, wr_data, `SPCR_IRQ_RW_MASK);
            `SPCR_OFF_PORT_ROLE: role_reg <= merge(role_reg, wr_data, `SPCR_ROLE_RW_MASK);
            `SPCR_OFF_HOT_PLUG: hp_reg <= merge(hp_reg, wr_data, `SPCR_HP_RW_MASK); // [RULE21]
            `SPCR_OFF_RATE_DEEMPH: rate_reg <= wr_data; // [RULE14]
            `SPCR_OFF_COMPLIANCE: compl_reg <= merge(compl_reg, wr_data, `SPCR_COMPL_RW_MASK);
            `SPCR_OFF_EVEN_PHY: even_phy_reg <= merge(even_phy_reg, wr_data, `SPCR_PHY_RW_MASK); // [RULE16]
            `SPCR_OFF_ODD_PHY: odd_phy_reg <= merge(odd_phy_reg, wr_data, `SPCR_PHY_RW_MASK);
            `SPCR_OFF_EVEN_HOLD: even_hold_reg <= merge(even_hold_reg, wr_data, `SPCR_HOLD_RW_MASK);
            `SPCR_OFF_ODD_HOLD: odd_hold_reg <= merge(odd_hold_reg, wr_data, `SPCR_HOLD_RW_MASK);
            `SPCR_OFF_L1_HDR:
            begin
               if (ld_wr && !sw_wr)
               begin
                  l1_next_reg <= ld_wdata[31:20];
               end
            end
            default:
            begin
            end
         endcase
      end
   end

   // Lane status sampling
   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         lane_reg <= 32'h00000000;
      end
      else
      begin
         lane_reg <= {12'h000, lane_up[7:4], lane_up[15:8], 4'h0, lane_up[3:0]}; // [RULE13]
      end
   end

   // Output reload and expander write tracking
   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         slot_output_pins <= 6'h00;
         expander_write_start <= 1'b0;
         exp_state_reg <= spcr_pkg::SPCR_EXP_IDLE;
         pending_reg <= 1'b0;
         exp_cnt_reg <= 32'h00000000;
      end
      else
      begin
         expander_write_start <= 1'b0;
         if (reload_hit)
         begin
            slot_output_pins <= wr_data[`SPCR_HP_RVAL_LSB +: 6]; // [RULE12]
            expander_write_start <= 1'b1;
            exp_state_reg <= spcr_pkg::SPCR_EXP_BUSY;
            pending_reg <= 1'b1; // [RULE8]
            exp_cnt_reg <= 32'h00000000;
         end
         else
         begin
            unique case (exp_state_reg)
               spcr_pkg::SPCR_EXP_IDLE:
               begin
                  pending_reg <= 1'b0;
               end
               spcr_pkg::SPCR_EXP_BUSY:
               begin
                  exp_cnt_reg <= exp_cnt_reg + 32'h00000001;
                  if (expander_write_done || exp_cnt_reg >= EXP_WRITE_CYC - 1)
                  begin
                     exp_state_reg <= spcr_pkg::SPCR_EXP_IDLE;
                     pending_reg <= 1'b0; // [RULE8]
                  end
               end
            endcase
         end
      end
   end

   // Slot timer period from the two-bit field
   always_comb
   begin
      tmr_sel = spcr_pkg::spcr_timer_t'(hp_reg[`SPCR_HP_TIMER_LSB +: 2]);
      unique case (tmr_sel)
         spcr_pkg::SPCR_TMR_256: tmr_limit = TIMER_128_CYC * 2; // [RULE5]
         spcr_pkg::SPCR_TMR_512: tmr_limit = TIMER_128_CYC * 4;
         default: tmr_limit = TIMER_128_CYC;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         tmr_cnt_reg <= 32'h00000000;
         slot_timer_tick <= 1'b0;
      end
      else if (tmr_cnt_reg >= tmr_limit - 1)
      begin
         tmr_cnt_reg <= 32'h00000000;
         slot_timer_tick <= 1'b1; // [RULE5]
      end
      else
      begin
         tmr_cnt_reg <= tmr_cnt_reg + 32'h00000001;
         slot_timer_tick <= 1'b0;
      end
   end

   // Interrupt routing
   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         legacy_interrupt_pin_n <= 1'b1;
         gpio_intx_msg <= 1'b0;
         doorbell_intx_msg <= 1'b0;
      end
      else
      begin
         legacy_interrupt_pin_n <= !((gpio_irq_req && irq_reg[`SPCR_IRQ_GPIO_PIN_BIT]) // [RULE1]
                                   || (doorbell_irq_req && irq_reg[`SPCR_IRQ_DBELL_PIN_BIT])); // [RULE2]
         gpio_intx_msg <= gpio_irq_req && !irq_reg[`SPCR_IRQ_GPIO_PIN_BIT]; // [RULE1]
         doorbell_intx_msg <= doorbell_irq_req && !irq_reg[`SPCR_IRQ_DBELL_PIN_BIT]; // [RULE2]
      end
   end

   // Port roles and configuration outputs
   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         upstream_port_number <= 4'h0;
         bridged_domain_port_number <= 4'h0;
         turn_off_message_enable <= 1'b0;
         slot_timer_period <= 2'h1;
         slot_power_good <= 16'h0000;
         bridged_port_serial_slot_enable <= 1'b0;
         downstream_serial_slot_enable <= 1'b1;
         wide_expander_select <= 1'b0;
         expander_pin_direction <= 1'b0;
         expander_pin_value <= 1'b0;
      end
      else
      begin
         upstream_port_number <= role_reg[`SPCR_ROLE_SW_BIT] ?
                                 role_reg[`SPCR_ROLE_UP_LSB +: 4] : strap_upstream_port; // [RULE3]
         bridged_domain_port_number <= role_reg[`SPCR_ROLE_SW_BIT] ?
                                       role_reg[`SPCR_ROLE_BR_LSB +: 4] : strap_bridged_port; // [RULE3]
         turn_off_message_enable <= hp_reg[`SPCR_HP_TURNOFF_BIT]; // [RULE4]
         slot_timer_period <= hp_reg[`SPCR_HP_TIMER_LSB +: 2];
         slot_power_good <= slot_power_good_inputs ^ {16{hp_reg[`SPCR_HP_PG_POL_BIT]}}; // [RULE6]
         bridged_port_serial_slot_enable <= hp_reg[`SPCR_HP_BR_SLOT_BIT]; // [RULE7]
         downstream_serial_slot_enable <= !hp_reg[`SPCR_HP_DN_DIS_BIT]; // [RULE9]
         wide_expander_select <= hp_reg[`SPCR_HP_WIDE_BIT]; // [RULE10]
         expander_pin_direction <= hp_reg[`SPCR_HP_DIR_BIT]; // [RULE11]
         expander_pin_value <= hp_reg[`SPCR_HP_VAL_BIT]; // [RULE11]
      end
   end

   // Test controls and training holds
   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         link_rate_sel <= 16'h0000;
         deemphasis_sel <= 16'h0000;
         compliance_enter <= 1'b0;
         port_loopback <= 16'h0000;
         port_scramble_off <= 16'h0000;
         port_compliance_rx <= 16'h0000;
         port_training_hold <= 16'h0000;
         port_quiet_hold <= 16'h0000;
      end
      else
      begin
         link_rate_sel <= rate_reg[15:0]; // [RULE14]
         deemphasis_sel <= rate_reg[31:16]; // [RULE14]
         compliance_enter <= (compl_reg[15:0] == 16'h0001); // [RULE15]
         port_loopback <= spread(even_phy_reg, odd_phy_reg, 0, 4); // [RULE16]
         port_scramble_off <= spread(even_phy_reg, odd_phy_reg, 1, 4);
         port_compliance_rx <= spread(even_phy_reg, odd_phy_reg, 2, 4);
         port_training_hold <= spread(even_hold_reg, odd_hold_reg, 0, 1); // [RULE17] [RULE19]
         port_quiet_hold <= spread(even_hold_reg, odd_hold_reg, 8, 1); // [RULE18] [RULE19]
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge ref_clk or negedge rst_sync_n)
   begin
      if (!rst_sync_n)
      begin
         sw_rdata <= 32'h00000000;
         sw_rvalid <= 1'b0;
      end
      else
      begin
         sw_rvalid <= sw_rd;
         if (sw_rd)
         begin
            unique case (sw_addr)
               `SPCR_OFF_IRQ_ROUTE: sw_rdata <= irq_reg;
               `SPCR_OFF_PORT_ROLE: sw_rdata <= role_reg;
               `SPCR_OFF_HOT_PLUG: sw_rdata <= hp_reg | ({31'h00000000, pending_reg} << `SPCR_HP_PENDING_BIT); // [RULE8]
               `SPCR_OFF_LANE_STAT: sw_rdata <= lane_reg & `SPCR_LANE_MASK; // [RULE13]
               `SPCR_OFF_RATE_DEEMPH: sw_rdata <= rate_reg;
               `SPCR_OFF_COMPLIANCE: sw_rdata <= compl_reg;
               `SPCR_OFF_EVEN_PHY: sw_rdata <= even_phy_reg;
               `SPCR_OFF_ODD_PHY: sw_rdata <= odd_phy_reg;
               `SPCR_OFF_EVEN_HOLD: sw_rdata <= even_hold_reg;
               `SPCR_OFF_ODD_HOLD: sw_rdata <= odd_hold_reg;
               `SPCR_OFF_L1_HDR: sw_rdata <= {l1_next_reg, `SPCR_L1_VERSION, `SPCR_L1_CAP_ID}; // [RULE20]
               default: sw_rdata <= 32'h00000000; // [RULE21]
            endcase
         end
      end
   end

   // Reload bit never stored, so it reads back zero
   chk_reload_self_clear: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
      !hp_reg[`SPCR_HP_RELOAD_BIT]) else $error("reload bit stuck"); // [RULE12]
   sequence reload_seq;
      reload_hit ##1 1'b1;
   endsequence
   chk_reload_pins: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
      reload_hit |=> (slot_output_pins == $past(wr_data[26:21]) && pending_reg)) else $error("reload failed"); // [RULE8]
   chk_irq_pin_route: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
      (gpio_irq_req && irq_reg[6]) |=> !legacy_interrupt_pin_n) else $error("gpio pin not driven"); // [RULE1]
   chk_irq_msg_route: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
      (doorbell_irq_req && !irq_reg[7]) |=> doorbell_intx_msg) else $error("doorbell msg missing"); // [RULE2]
   chk_role_select: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
      role_reg[15] |=> (upstream_port_number == $past(role_reg[11:8]))) else $error("upstream select wrong"); // [RULE3]
   chk_hold_map: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
      even_hold_reg[1] |=> port_training_hold[2]) else $error("hold map wrong"); // [RULE19]
   chk_quiet_map: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
      odd_hold_reg[8] |=> port_quiet_hold[1]) else $error("quiet map wrong"); // [RULE18]
   chk_pg_polarity: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
      hp_reg[6] |=> (slot_power_good == ~$past(slot_power_good_inputs))) else $error("polarity wrong"); // [RULE6]
   chk_pending_clears: assert property (@(posedge ref_clk) disable iff (!rst_sync_n)
      reload_seq |-> ##[0:70] !pending_reg) else $error("pending never cleared"); // [RULE8]
endmodule
